/* File: rtl/atc_pkg.sv */
// Summary of operation
// - opcode 0x228 copies accumulator to port output cfg 0, one cycle
// - opcode 0x229 copies accumulator to port output cfg 1, one cycle
// - opcode 0x22a copies accumulator to port output cfg 2, one cycle
// - opcode 0x22b copies accumulator to port output cfg 3, one cycle
// - opcode 0x217 copies accumulator to interrupt control 1, one cycle
// - opcode 0x202 copies accumulator to serial control 1, one cycle
package atc_pkg;

  // ***************************************************************
  // widths and opcodes
  // ***************************************************************
  localparam int unsigned OP_W    = 10;
  localparam int unsigned DAT_W   = 4;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned NUM_CFG = 6;
  localparam int unsigned CNT_W   = 8;

  localparam logic [OP_W-1:0] OP_LOAD_PCFG0 = 10'h228;
  localparam logic [OP_W-1:0] OP_LOAD_PCFG1 = 10'h229;
  localparam logic [OP_W-1:0] OP_LOAD_PCFG2 = 10'h22a;
  localparam logic [OP_W-1:0] OP_LOAD_PCFG3 = 10'h22b;
  localparam logic [OP_W-1:0] OP_LOAD_IRQ1  = 10'h217;
  localparam logic [OP_W-1:0] OP_LOAD_SER1  = 10'h202;

  // ***************************************************************
  // register map, fields and reset values
  // ***************************************************************
  localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STAT     = 8'h04;
  localparam logic [ADDR_W-1:0] REG_INJECT   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CFG_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] REG_CFG_LAST = 8'h24;

  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned STAT_PEND_BIT = 0;
  localparam int unsigned STAT_DEST_LSB = 4;
  localparam int unsigned STAT_CNT_LSB  = 8;
  localparam int unsigned INJ_ACC_LSB   = 16;

  localparam logic              CTRL_EN_RST = 1'b1;
  localparam logic [DAT_W-1:0]  CFG_RST     = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_RST     = 8'h00;
  localparam logic [OP_W-1:0]   INJ_OP_RST  = 10'h000;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [2:0] {
    DEST_NONE,
    DEST_PCFG0,
    DEST_PCFG1,
    DEST_PCFG2,
    DEST_PCFG3,
    DEST_IRQ1,
    DEST_SER1
  } atc_dest_t;

  typedef struct packed {
    logic              valid;
    logic [OP_W-1:0]   opcode;
    logic [DAT_W-1:0]  acc;
  } atc_instr_t;

  typedef struct packed {
    logic [DAT_W-1:0] port_output_cfg0;
    logic [DAT_W-1:0] port_output_cfg1;
    logic [DAT_W-1:0] port_output_cfg2;
    logic [DAT_W-1:0] port_output_cfg3;
    logic [DAT_W-1:0] irq_ctrl1;
    logic [DAT_W-1:0] serial_ctrl1;
  } atc_cfg_t;

  // opcode to destination; anything else is not ours
  function automatic atc_dest_t atc_decode(input logic [OP_W-1:0] op);
    case (op)
      OP_LOAD_PCFG0: atc_decode = DEST_PCFG0;
      OP_LOAD_PCFG1: atc_decode = DEST_PCFG1;
      OP_LOAD_PCFG2: atc_decode = DEST_PCFG2;
      OP_LOAD_PCFG3: atc_decode = DEST_PCFG3;
      OP_LOAD_IRQ1:  atc_decode = DEST_IRQ1;
      OP_LOAD_SER1:  atc_decode = DEST_SER1;
      default:       atc_decode = DEST_NONE;
    endcase
  endfunction : atc_decode

endpackage : atc_pkg

/* File: rtl/atc_op_decode.sv */
`timescale 1ns/100ps
module atc_op_decode
  import atc_pkg::*;
(
  input  atc_instr_t instr,
  input  wire logic  enable,
  output atc_dest_t  dest,
  output wire logic  hit
);

  // ***************************************************************
  // opcode match
  // ***************************************************************
  // a disabled decoder reports no destination at all
  atc_dest_t raw_dest;
  assign raw_dest = atc_decode(instr.opcode);
  assign dest     = (instr.valid && enable) ? raw_dest : DEST_NONE;
  assign hit      = (dest != DEST_NONE);

endmodule : atc_op_decode

/* File: rtl/atc_ctrl_bank.sv */
`timescale 1ns/100ps
module atc_ctrl_bank
  import atc_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  atc_dest_t             wr_dest,
  input  wire logic [DAT_W-1:0] wr_data,
  input  wire logic [2:0]       rd_idx,
  output logic      [DAT_W-1:0] rd_data,
  output atc_cfg_t              cfg
);

  // ***************************************************************
  // storage
  // ***************************************************************
  logic [DAT_W-1:0] mem [NUM_CFG];
  wire  logic [2:0] wr_idx;
  wire  logic       wr_en;

  // destination code minus one is the slot
  assign wr_idx = 3'(wr_dest) - 3'h1;
  assign wr_en  = (wr_dest != DEST_NONE);

  // one slot written per cycle, the rest keep their value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        mem[i] <= CFG_RST;
      end
    end else if (ce && wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // registered read port for the bus side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= CFG_RST;
    end else if (ce) begin
      rd_data <= (rd_idx < 3'(NUM_CFG)) ? mem[rd_idx] : CFG_RST;
    end
  end

  // peripherals see the stored values directly
  assign cfg.port_output_cfg0 = mem[0];
  assign cfg.port_output_cfg1 = mem[1];
  assign cfg.port_output_cfg2 = mem[2];
  assign cfg.port_output_cfg3 = mem[3];
  assign cfg.irq_ctrl1        = mem[4];
  assign cfg.serial_ctrl1     = mem[5];

endmodule : atc_ctrl_bank

/* File: rtl/atc_xfer_core.sv */
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/100ps
module atc_xfer_core
  import atc_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output wire logic              pready,
  output wire logic              pslverr,
  input  atc_instr_t             instr,
  output wire logic              instr_taken,
  output atc_cfg_t               cfg,
  output logic                   xfer_done,
  output wire logic              skip_req,
  output wire logic              carry_we,
  output wire logic              acc_we
);

  // ***************************************************************
  // declarations
  // ***************************************************************
  logic              decode_en;
  logic              inj_pend;
  logic [OP_W-1:0]   inj_op;
  logic [DAT_W-1:0]  inj_acc;
  logic [CNT_W-1:0]  exec_cnt;
  atc_dest_t         last_dest;
  logic [31:0]       prdata_q;
  logic              cfg_rd_q;

  atc_instr_t        exec;
  atc_dest_t         dest;
  wire logic         hit;
  wire logic         inj_go;
  wire logic [DAT_W-1:0] bank_rd;

  wire logic         apb_setup;
  wire logic         apb_access;
  wire logic         apb_wr;
  wire logic         addr_aligned;
  wire logic         addr_ctrl;
  wire logic         addr_stat;
  wire logic         addr_inj;
  wire logic         addr_cfg;
  wire logic         addr_ok;
  wire logic [2:0]   cfg_idx;
  wire logic [ADDR_W-1:0] cfg_off;
  logic [31:0]       stat_word;
  logic [31:0]       rd_word;

  // ***************************************************************
  // instruction select
  // ***************************************************************
  // the fetched instruction always wins; an injected one waits for
  // a free cycle so the core never stalls on bus traffic
  assign inj_go    = inj_pend && !instr.valid;
  assign exec.valid  = instr.valid || inj_pend;
  assign exec.opcode = instr.valid ? instr.opcode : inj_op;
  assign exec.acc    = instr.valid ? instr.acc : inj_acc;
  assign instr_taken = instr.valid && hit;

  atc_op_decode u_dec (
    .instr  (exec),
    .enable (decode_en),
    .dest   (dest),
    .hit    (hit)
  );

  // ***************************************************************
  // destination registers
  // ***************************************************************
  // one write per instruction cycle, new value seen the next cycle
  atc_ctrl_bank u_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .wr_dest (dest),
    .wr_data (exec.acc),
    .rd_idx  (cfg_idx),
    .rd_data (bank_rd),
    .cfg     (cfg)
  );

  // these transfers never touch carry, skip or the accumulator
  assign skip_req = 1'b0;
  assign carry_we = 1'b0;
  assign acc_we   = 1'b0;

  // ***************************************************************
  // execution bookkeeping
  // ***************************************************************
  // completion pulse and counters follow each executed transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_done <= 1'b0;
      exec_cnt  <= CNT_RST;
      last_dest <= DEST_NONE;
    end else if (ce) begin
      xfer_done <= hit;
      if (hit) begin
        exec_cnt  <= exec_cnt + 8'h01;
        last_dest <= dest;
      end
    end
  end

  // ***************************************************************
  // apb decode
  // ***************************************************************
  assign apb_setup    = psel && !penable;
  assign apb_access   = psel && penable;
  assign apb_wr       = apb_access && pwrite && addr_ok;
  assign addr_aligned = (paddr[1:0] == 2'b00);
  assign addr_ctrl    = (paddr == REG_CTRL);
  assign addr_stat    = (paddr == REG_STAT);
  assign addr_inj     = (paddr == REG_INJECT);
  assign addr_cfg     = addr_aligned && (paddr >= REG_CFG_BASE)
                        && (paddr <= REG_CFG_LAST);
  assign addr_ok      = addr_ctrl || addr_stat || addr_inj || addr_cfg;
  assign cfg_off      = paddr - REG_CFG_BASE;
  assign cfg_idx      = cfg_off[4:2];

  // zero wait states; read data is staged during the setup cycle
  assign pready  = apb_access;
  assign pslverr = apb_access && !addr_ok;
  assign prdata  = cfg_rd_q ? {28'h0000000, bank_rd} : prdata_q;

  // status word: pending injection, last destination, count
  always_comb begin
    stat_word = 32'h00000000;
    stat_word[STAT_PEND_BIT] = inj_pend;
    stat_word[STAT_DEST_LSB +: 3] = 3'(last_dest);
    stat_word[STAT_CNT_LSB +: CNT_W] = exec_cnt;
  end

  // read mux for the non bank registers
  always_comb begin
    rd_word = 32'h00000000;
    if (addr_ctrl) begin
      rd_word[CTRL_EN_BIT] = decode_en;
    end else if (addr_stat) begin
      rd_word = stat_word;
    end else if (addr_inj) begin
      rd_word[OP_W-1:0] = inj_op;
      rd_word[INJ_ACC_LSB +: DAT_W] = inj_acc;
    end
  end

  // ***************************************************************
  // apb registers
  // ***************************************************************
  // read data is captured at the setup edge and held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      cfg_rd_q <= 1'b0;
    end else if (ce && apb_setup) begin
      prdata_q <= rd_word;
      cfg_rd_q <= addr_cfg && !pwrite;
    end
  end

  // decode enable gates both the core and the injection path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decode_en <= CTRL_EN_RST;
    end else if (ce && apb_wr && addr_ctrl) begin
      decode_en <= pwdata[CTRL_EN_BIT];
    end
  end

  // injection: a new write in the same cycle as execution stays pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inj_pend <= 1'b0;
      inj_op   <= INJ_OP_RST;
      inj_acc  <= CFG_RST;
    end else if (ce) begin
      if (apb_wr && addr_inj) begin
        inj_pend <= 1'b1;
        inj_op   <= pwdata[OP_W-1:0];
        inj_acc  <= pwdata[INJ_ACC_LSB +: DAT_W];
      end else if (inj_go) begin
        inj_pend <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_exec(logic [OP_W-1:0] op);
    ce && decode_en && exec.valid && (exec.opcode == op);
  endsequence

  sequence s_any_xfer;
    ce && exec.valid && decode_en && (atc_decode(exec.opcode) != DEST_NONE);
  endsequence

  pcfg0_load_a: assert property (
    s_exec(OP_LOAD_PCFG0) |=>
      cfg.port_output_cfg0 == $past(exec.acc))
    else $error("port cfg0 not loaded from accumulator");

  pcfg1_load_a: assert property (
    s_exec(OP_LOAD_PCFG1) |=>
      cfg.port_output_cfg1 == $past(exec.acc))
    else $error("port cfg1 not loaded from accumulator");

  pcfg2_load_a: assert property (
    s_exec(OP_LOAD_PCFG2) |=>
      cfg.port_output_cfg2 == $past(exec.acc))
    else $error("port cfg2 not loaded from accumulator");

  pcfg3_load_a: assert property (
    s_exec(OP_LOAD_PCFG3) |=>
      cfg.port_output_cfg3 == $past(exec.acc))
    else $error("port cfg3 not loaded from accumulator");

  irq1_load_a: assert property (
    s_exec(OP_LOAD_IRQ1) |=> cfg.irq_ctrl1 == $past(exec.acc))
    else $error("irq ctrl1 not loaded from accumulator");

  ser1_load_a: assert property (
    s_exec(OP_LOAD_SER1) |=> cfg.serial_ctrl1 == $past(exec.acc))
    else $error("serial ctrl1 not loaded from accumulator");

  others_held_a: assert property (
    s_exec(OP_LOAD_SER1) |=>
      $stable(cfg.port_output_cfg0) && $stable(cfg.irq_ctrl1))
    else $error("transfer disturbed a foreign register");

  no_side_a: assert property (
    s_any_xfer |-> !skip_req && !carry_we && !acc_we ##1 xfer_done)
    else $error("transfer caused a side effect or no completion");

  idle_hold_a: assert property (
    !hit || !ce |=> $stable(cfg))
    else $error("config changed without a transfer");

  // a field may only move in a cycle that names it as destination
  sequence s_leaves(atc_dest_t d);
    !(ce && (dest == d));
  endsequence

  pcfg0_kept_a: assert property (
    s_leaves(DEST_PCFG0) |=> $stable(cfg.port_output_cfg0))
    else $error("port cfg0 moved without its transfer");

  pcfg1_kept_a: assert property (
    s_leaves(DEST_PCFG1) |=> $stable(cfg.port_output_cfg1))
    else $error("port cfg1 moved without its transfer");

  pcfg2_kept_a: assert property (
    s_leaves(DEST_PCFG2) |=> $stable(cfg.port_output_cfg2))
    else $error("port cfg2 moved without its transfer");

  pcfg3_kept_a: assert property (
    s_leaves(DEST_PCFG3) |=> $stable(cfg.port_output_cfg3))
    else $error("port cfg3 moved without its transfer");

  irq1_kept_a: assert property (
    s_leaves(DEST_IRQ1) |=> $stable(cfg.irq_ctrl1))
    else $error("irq ctrl1 moved without its transfer");

  ser1_kept_a: assert property (
    s_leaves(DEST_SER1) |=> $stable(cfg.serial_ctrl1))
    else $error("serial ctrl1 moved without its transfer");

  // completion pulse only ever follows an executed transfer
  done_pulse_a: assert property (
    ce && !hit |=> !xfer_done)
    else $error("completion pulse without a transfer");

  // a low enable must freeze every register of the block
  ce_frozen_a: assert property (
    !ce |=> $stable(cfg) && $stable(xfer_done) && $stable(exec_cnt)
      && $stable(decode_en) && $stable(inj_pend))
    else $error("state moved while clock enable was low");

  // the fetched word keeps priority over a queued injection
  core_first_a: assert property (
    ce && instr.valid && inj_pend |=> inj_pend)
    else $error("queued injection lost behind a fetched word");

  // a bus write to the injection register queues that word's opcode bits
  inj_load_a: assert property (
    ce && apb_wr && addr_inj |=>
      inj_pend && (inj_op == OP_W'($past(pwdata))))
    else $error("injection write not queued");

  // refused writes leave the enable untouched
  bad_write_a: assert property (
    ce && apb_access && pwrite && !addr_ok |=> $stable(decode_en))
    else $error("unmapped write changed the decode enable");

endmodule : atc_xfer_core

/* File: testbench/atc_fetch_model.sv */
`timescale 1ns/100ps
module atc_fetch_model
  import atc_pkg::*;
(
  input  wire logic pclk,
  output atc_instr_t instr
);
  // ***************************************************************
  // core fetch side: one word per cycle, released when idle
  // ***************************************************************
  atc_instr_t last;

  initial begin
    instr = '0;
    last  = '0;
  end

  // present one word just after an edge; back to back calls stream
  task automatic put(input logic [OP_W-1:0] op, input logic [DAT_W-1:0] a);
    @(posedge pclk);
    last = '{1'b1, op, a};
    instr <= last;
  endtask : put

  // released bus shows inverted data so stale words cannot match
  task automatic idle();
    @(posedge pclk);
    instr <= '{1'b0, ~last.opcode, ~last.acc};
  endtask : idle
endmodule : atc_fetch_model

/* File: testbench/acc_to_ctrl_reg_transfer_decode_test.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  mismatches++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
  end end
module acc_to_ctrl_reg_transfer_decode_test
  import atc_pkg::*;
;
  // ***************************************************************
  // clock, nets and counters
  // ***************************************************************
  logic               pclk, presetn, ce, psel, penable, pwrite;
  logic [ADDR_W-1:0]  paddr;
  logic [31:0]        pwdata, r;
  wire logic [31:0]   prdata;
  wire logic          pready, pslverr, taken, skip_req, carry_we, acc_we;
  logic               xfer_done, e, en, pv;
  atc_instr_t         instr;
  atc_cfg_t           cfg, exp;
  logic [OP_W-1:0]    op, pop;
  logic [DAT_W-1:0]   a, pa;
  int                 mismatches, checks_done, cyc, i;
  integer             seed = 32140;

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  atc_fetch_model m (.pclk(pclk), .instr(instr));

  atc_xfer_core dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr(instr), .instr_taken(taken), .cfg(cfg), .xfer_done(xfer_done),
    .skip_req(skip_req), .carry_we(carry_we), .acc_we(acc_we));

  // ***************************************************************
  // expectation functions and bus tasks
  // ***************************************************************
  function automatic atc_cfg_t apply(atc_cfg_t c, logic [9:0] o,
                                     logic [3:0] d);
    case (o)
      10'h228: c.port_output_cfg0 = d;
      10'h229: c.port_output_cfg1 = d;
      10'h22a: c.port_output_cfg2 = d;
      10'h22b: c.port_output_cfg3 = d;
      10'h217: c.irq_ctrl1 = d;
      10'h202: c.serial_ctrl1 = d;
      default: c = c;
    endcase
    return c;
  endfunction : apply

  // the six opcodes of the transfer group
  function automatic logic grp(input logic [9:0] o);
    return o inside {10'h228, 10'h229, 10'h22a, 10'h22b, 10'h217, 10'h202};
  endfunction : grp

  // check effects of the word taken at the edge just passed
  task automatic edge_chk(input logic v, input logic [9:0] o,
                          input logic [3:0] d);
    logic hit;
    #1;
    hit = v && en && grp(o);
    if (hit) exp = apply(exp, o, d);
    `CHK(cfg, exp)
    `CHK(xfer_done, hit)
    `CHK({skip_req, carry_we, acc_we}, 3'b000)
  endtask : edge_chk

  // apb master; waits on pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    presetn = 1'b0;
    ce      = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    exp     = '0;
    en      = 1'b1;
    pv      = 1'b0;
    pop     = '0;
    pa      = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    `CHK({cfg, r[0]}, {exp, CTRL_EN_RST})
    $display("test reset done");
    // random stream with back-to-back words and idle gaps
    for (i = 0; i < 300; i++) begin
      op = (($random(seed) & 7) == 7) ? 10'($random(seed)) :
           OP_LOAD_PCFG0 + 10'($random(seed) & 3);
      if (($random(seed) & 7) == 5) op = OP_LOAD_IRQ1;
      if (($random(seed) & 7) == 6) op = OP_LOAD_SER1;
      a = 4'($random(seed));
      m.put(op, a);
      edge_chk(pv, pop, pa);
      `CHK(taken, en && grp(op))
      {pv, pop, pa} = {1'b1, op, a};
      if (($random(seed) & 3) == 0) begin
        m.idle();
        edge_chk(pv, pop, pa);
        pv = 1'b0;
      end
    end
    m.idle();
    edge_chk(pv, pop, pa);
    $display("test random stream done");
    // decode disabled: group word must be ignored
    apb(1'b1, REG_CTRL, 32'h0);
    en = 1'b0;
    m.put(OP_LOAD_PCFG0, ~exp.port_output_cfg0);
    m.idle();
    edge_chk(1'b1, OP_LOAD_PCFG0, ~exp.port_output_cfg0);
    apb(1'b1, REG_CTRL, 32'h1);
    en = 1'b1;
    // clock enable low: a group word must leave no trace
    @(posedge pclk);
    ce <= 1'b0;
    m.put(OP_LOAD_PCFG1, ~exp.port_output_cfg1);
    m.idle();
    edge_chk(1'b0, OP_LOAD_PCFG1, ~exp.port_output_cfg1);
    @(posedge pclk);
    ce <= 1'b1;
    $display("test disable done");
    // injected word, read-only window, unmapped address
    a = ~exp.serial_ctrl1;
    apb(1'b1, REG_INJECT, {12'h0, a, 6'h0, OP_LOAD_SER1});
    repeat (3) @(posedge pclk);
    #1 exp = apply(exp, OP_LOAD_SER1, a);
    `CHK(cfg, exp)
    apb(1'b1, REG_CFG_BASE, {28'h0, ~exp.port_output_cfg0});
    for (i = 0; i < 6; i++) begin
      apb(1'b0, REG_CFG_BASE + 8'(4 * i), 32'h0);
      `CHK(r, {28'h0, 4'(exp >> (20 - 4 * i))})
    end
    apb(1'b0, 8'h40, 32'h0);
    `CHK({e, r}, 33'h1_0000_0000)
    $display("test register window done");
    tally_and_finish();
  end
endmodule : acc_to_ctrl_reg_transfer_decode_test
